//--- rtl/ird_map.svh
/*
  Constants for the instruction holding register and two-operand decoder:
  reset and forced patterns, field positions and micro-PC branch codes.
  Assumes it is included by bare name from the package and the design modules.
*/
`ifndef IRD_MAP_SVH
`define IRD_MAP_SVH

// Width of the instruction word.
`define IRD_IR_W          16
// Pattern after reset and after a service microstep (conditional branch).
`define IRD_IR_RESET      16'h8000
`define IRD_IR_SERVICE    16'h8000
// Pattern after a double bus fault (halt).
`define IRD_IR_HALT       16'h0000
// Field positions inside the instruction word.
`define IRD_OP_HI         15
`define IRD_OP_LO         12
`define IRD_SMODE_HI      11
`define IRD_SMODE_LO      9
`define IRD_DMODE_HI      5
`define IRD_DMODE_LO      3
// Opcode values of bits 14..12 and of bits 15..12.
`define IRD_OP3_NONE      3'h0
`define IRD_OP3_MOV       3'h1
`define IRD_OP3_CMP       3'h2
`define IRD_OP3_BIT       3'h3
`define IRD_OP3_EXT       3'h7
`define IRD_OP4_SUB       4'he
`define IRD_OP4_FLOAT     4'hf
// Micro-PC bits 7..3 forced during a two-operand dispatch.
`define IRD_MPC_MOV       5'h11
`define IRD_MPC_SUB       5'h14
`define IRD_MPC_NONMODIFYING_CLASS    5'h17
`define IRD_MPC_MOD_NZ    5'h0c
`define IRD_MPC_DOP       5'h09
// Jump and subroutine-call opcodes checked for an illegal register mode.
`define IRD_JMP_OP        10'h001
`define IRD_JSR_OP        7'h04

`endif

//--- rtl/ird_pkg.sv
/*
  Types shared by the instruction decoder modules.
  Assumes ird_map.svh is on the include path.
*/
package ird_pkg;
  `include "ird_map.svh"

  // Instruction word type.
  typedef logic [`IRD_IR_W-1:0] ird_word_t;

  // Two-operand decode class, one-hot.
  typedef enum logic [5:0] {
    IRD_CL_NONE   = 6'h01,
    IRD_CL_MOV    = 6'h02,
    IRD_CL_SUB    = 6'h04,
    IRD_CL_NONMODIFYING_CLASS = 6'h08,
    IRD_CL_MOD    = 6'h10,
    IRD_CL_RESV   = 6'h20
  } ird_class_e;
endpackage

//--- rtl/ird_dec_if.sv
/*
  Carrier between the instruction register top and its two-operand decoder.
  Assumes both ends run on the same clock; the decoder is purely combinational.
*/
interface ird_dec_if;
  import ird_pkg::*;
  ird_word_t  ir;            // Held instruction word.
  logic       float_present; // Floating-point option fitted.
  ird_class_e cls;           // Decoded class.
  logic [7:0] mpc_bits;      // Micro-PC bits to force, logic 1 means pull low.
  logic [7:0] mpc_drive;     // Which micro-PC bits are forced.
  logic       trap_class0;   // Trap-class bit 0 value.
  logic       illegal;       // Illegal instruction and mode pairing.

  modport top (output ir, output float_present, input cls, input mpc_bits,
               input mpc_drive, input trap_class0, input illegal);
  modport dec (input ir, input float_present, output cls, output mpc_bits,
               output mpc_drive, output trap_class0, output illegal);
endinterface

//--- rtl/ird_dop_decode.sv
/*
  Combinational two-operand decoder: classifies the held instruction and
  produces the micro-PC branch bits and trap-class bit for a dispatch.
  Assumes the top samples its results while a dispatch is requested, and the class also during a generic ALU step.
*/
module ird_dop_decode
  import ird_pkg::*;
(
  // Link to the top.
  ird_dec_if.dec dec
);

  // Opcode and mode fields.
  logic [2:0] op3;   // Bits 14..12.
  logic [3:0] op4;   // Bits 15..12.
  logic       sm0;   // Source mode zero.
  logic       dm0;   // Destination mode zero.

  // Returns the micro-PC bits 7..3 for a class.
  function automatic logic [4:0] mpc_hi(input ird_class_e c, input logic both0);
    logic [4:0] r;
    r = `IRD_MPC_DOP;
    case (c)
      IRD_CL_MOV:    r = both0 ? `IRD_MPC_MOV : `IRD_MPC_DOP;
      IRD_CL_SUB:    r = both0 ? `IRD_MPC_SUB : `IRD_MPC_DOP;
      IRD_CL_NONMODIFYING_CLASS: r = both0 ? `IRD_MPC_NONMODIFYING_CLASS : `IRD_MPC_DOP;
      IRD_CL_MOD:    r = both0 ? `IRD_MPC_DOP : `IRD_MPC_MOD_NZ;
      default:       r = 5'h00;
    endcase
    return r;
  endfunction

  // Classify the opcode; length varies, so the wider fields are checked too.
  always_comb
  begin
    op3 = dec.ir[`IRD_OP_HI-1:`IRD_OP_LO];
    op4 = dec.ir[`IRD_OP_HI:`IRD_OP_LO];
    sm0 = (dec.ir[`IRD_SMODE_HI:`IRD_SMODE_LO] == 3'h0);
    dm0 = (dec.ir[`IRD_DMODE_HI:`IRD_DMODE_LO] == 3'h0);
    dec.cls = IRD_CL_NONE;
    if (op4 == `IRD_OP4_FLOAT)
    begin
      // Float range traps unless the option is fitted.
      dec.cls = dec.float_present ? IRD_CL_NONE : IRD_CL_RESV;
    end
    else if (op4 == `IRD_OP4_SUB)
    begin
      dec.cls = IRD_CL_SUB;
    end
    else if (op3 == `IRD_OP3_MOV)
    begin
      dec.cls = IRD_CL_MOV;
    end
    else if (op3 == `IRD_OP3_CMP || op3 == `IRD_OP3_BIT)
    begin
      dec.cls = IRD_CL_NONMODIFYING_CLASS;
    end
    else if (op3 != `IRD_OP3_NONE && op3 != `IRD_OP3_EXT)
    begin
      dec.cls = IRD_CL_MOD;
    end
    // Register mode is illegal as a jump or call target.
    dec.illegal = dm0 && (dec.ir[15:6] == `IRD_JMP_OP || dec.ir[15:9] == `IRD_JSR_OP);
  end

  // Build the branch bits; reserved codes force nothing and clear the trap bit.
  always_comb
  begin
    dec.mpc_bits    = 8'h00;
    dec.mpc_drive   = 8'h00;
    dec.trap_class0 = 1'b0;
    if (dec.cls == IRD_CL_RESV)
    begin
      dec.trap_class0 = 1'b0;
    end
    else if (dec.cls != IRD_CL_NONE)
    begin
      dec.trap_class0 = 1'b1;
      dec.mpc_bits    = {mpc_hi(dec.cls, sm0 && dm0), dec.ir[`IRD_SMODE_HI:`IRD_SMODE_LO]};
      dec.mpc_drive   = 8'hff;
    end
  end

endmodule

//--- rtl/ird_top.sv
/*
  Instruction holding register with its two-operand dispatch decoder.
  Assumes one 10 MHz clock; the processor clock pulse, service, fault and
  dispatch inputs come from logic on that clock. The micro-PC lines are
  wired-OR and open-drain: ground is logic 1, resolved outside this block.
*/
module ird_top
  import ird_pkg::*;
(
  // Clock and reset.
  input  wire logic                 i_mclk,
  input  wire logic                 i_rstn,
  // Instruction load.
  input  wire logic                 i_processor_clock_pulse,
  input  wire logic                 i_load_instruction_strobe,
  input  wire logic [`IRD_IR_W-1:0] i_source_select_multiplexer,
  // Forcing events.
  input  wire logic                 i_service_branch_test,
  input  wire logic                 i_bus_fault,
  input  wire logic                 i_double_fault_guard_enable,
  // Dispatch control.
  input  wire logic                 i_decode_dispatch_request,
  input  wire logic                 i_float_option_present,
  input  wire logic                 i_generic_alu_step,
  // Held instruction.
  output logic [`IRD_IR_W-1:0]      o_instruction_holding_register,
  // Wired-OR micro-PC bits 7..0.
  output logic [7:0]                o_micro_program_counter_out,
  output logic [7:0]                o_micro_program_counter_oe_n,
  // Decode results.
  output logic                      o_trap_class_bit0,
  output logic                      o_reserved_trap,
  output logic                      o_illegal_trap,
  output logic                      o_aux_alu_active,
  output logic [2:0]                o_aux_alu_op
);

  // Register state and next values.
  // Each group of state has one combinational process that works out the
  // next values and one clocked process that only registers them.
  // Every output of this module is read straight from one of these flops,
  // so the control store never sees a combinational glitch on its lines.
  ird_word_t  ir_reg;           // Instruction holding register.
  ird_word_t  ir_next;
  logic       svc_reg;          // Previous service level, for edge detect.
  logic       svc_next;
  logic [7:0] oe_n_reg;         // Active-low enables of the micro-PC pins.
  logic [7:0] oe_n_next;
  logic       tc0_reg;          // Trap-class bit 0.
  logic       tc0_next;
  logic       resv_reg;         // Reserved-instruction trap.
  logic       resv_next;
  logic       ill_reg;          // Illegal pairing trap.
  logic       ill_next;
  logic       aux_reg;          // Auxiliary ALU control in charge.
  logic       aux_next;
  logic [2:0] aop_reg;          // Auxiliary ALU function.
  logic [2:0] aop_next;
  logic [7:0] mpc_out_reg;      // Level put on the micro-PC pins, always ground.
  logic [7:0] mpc_out_next;

  // Decoder link.
  // The decoder is purely combinational and reads the registered word, so
  // its results settle within the cycle after the word is registered, before
  // the dispatch flops take them at the next edge. The float option level is passed through untouched.
  ird_dec_if dec_if ();

  assign dec_if.ir            = ir_reg;
  assign dec_if.float_present = i_float_option_present;

  // Two-operand decoder instance.
  ird_dop_decode u_dop
  (
    .dec (dec_if.dec)
  );

  // Next instruction word: guarded fault beats service, service beats load.
  // The order matters: a second bus fault inside the trap sequence must
  // halt the processor even if a load or a service step falls in the same
  // cycle, and the service pattern must win over a stale load so that a
  // halt is never decoded right after an initialize. A fault without the
  // guard is ignored here; the trap sequence deals with it.
  always_comb
  begin
    ir_next  = ir_reg;
    svc_next = i_service_branch_test;
    if (i_bus_fault && i_double_fault_guard_enable)
    begin
      // Double fault: clear to the halt pattern.
      ir_next = `IRD_IR_HALT;
    end
    else if (svc_reg && !i_service_branch_test)
    begin
      // Service trailing edge: clear all bits, set the top one.
      ir_next = `IRD_IR_SERVICE;
    end
    else if (i_load_instruction_strobe && i_processor_clock_pulse)
    begin
      // Processor clock pulse high together with the strobe: load.
      ir_next = i_source_select_multiplexer;
    end
    // An unguarded fault takes no branch above and keeps the word.
  end

  // Register the instruction and the service edge detector.
  // The edge detector resets to the idle low level of the service input,
  // so no false trailing edge is seen in the first cycle after reset.
  // The reset word is the service pattern, a conditional branch.
  always_ff @(posedge i_mclk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      ir_reg  <= `IRD_IR_RESET;
      svc_reg <= 1'b0;
    end
    else
    begin
      ir_reg  <= ir_next;
      svc_reg <= svc_next;
    end
  end

  // Dispatch outputs; lines are released whenever no dispatch is requested.
  // The micro-PC lines are open-drain and wired-OR with the control store:
  // this block only ever pulls a line to ground, which the sequencer reads
  // as a one. Releasing every enable outside a dispatch lets the control
  // store's own next address pass through unchanged.
  always_comb
  begin
    mpc_out_next = 8'h00;
    oe_n_next = 8'hff;
    tc0_next  = 1'b0;
    resv_next = 1'b0;
    ill_next  = 1'b0;
    if (i_decode_dispatch_request)
    begin
      // A forced one is a driven-low pin, so enable where the bit is one.
      oe_n_next = ~(dec_if.mpc_bits & dec_if.mpc_drive);
      tc0_next  = dec_if.trap_class0;
      resv_next = (dec_if.cls == IRD_CL_RESV);
      ill_next  = dec_if.illegal;
    end
  end

  // Auxiliary ALU control: follow the opcode during a generic ALU step.
  // Only recognised two-operand classes take over the ALU function; a
  // reserved or unknown opcode leaves the microword in charge.
  always_comb
  begin
    aux_next = 1'b0;
    aop_next = 3'h0;
    if (i_generic_alu_step && dec_if.cls != IRD_CL_NONE && dec_if.cls != IRD_CL_RESV)
    begin
      aux_next = 1'b1;
      aop_next = ir_reg[`IRD_OP_HI-1:`IRD_OP_LO];
    end
  end

  // Register all decode outputs; outputs come straight from these flops.
  // In reset every line is released and every flag is low, so the
  // sequencer starts from its own address.
  always_ff @(posedge i_mclk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      mpc_out_reg <= 8'h00;
      oe_n_reg <= 8'hff;
      tc0_reg  <= 1'b0;
      resv_reg <= 1'b0;
      ill_reg  <= 1'b0;
      aux_reg  <= 1'b0;
      aop_reg  <= 3'h0;
    end
    else
    begin
      mpc_out_reg <= mpc_out_next;
      oe_n_reg <= oe_n_next;
      tc0_reg  <= tc0_next;
      resv_reg <= resv_next;
      ill_reg  <= ill_next;
      aux_reg  <= aux_next;
      aop_reg  <= aop_next;
    end
  end

  // Output connections; the pin level driven is always ground.
  // The enables alone decide which micro-PC lines are pulled low.
  assign o_instruction_holding_register = ir_reg;
  assign o_micro_program_counter_out    = mpc_out_reg;
  assign o_micro_program_counter_oe_n   = oe_n_reg;
  assign o_trap_class_bit0              = tc0_reg;
  assign o_reserved_trap                = resv_reg;
  assign o_illegal_trap                 = ill_reg;
  assign o_aux_alu_active               = aux_reg;
  assign o_aux_alu_op                   = aop_reg;

endmodule

//--- verification/ird_top_properties.sv
/*
  Port-level assertions for ird_top.
  Assumes a bind to ird_top and a single clock domain.
*/
module ird_top_properties (
  // Inputs of the block.
  input wire logic        i_mclk,
  input wire logic        i_rstn,
  input wire logic        i_processor_clock_pulse,
  input wire logic        i_load_instruction_strobe,
  input wire logic [15:0] i_source_select_multiplexer,
  input wire logic        i_service_branch_test,
  input wire logic        i_bus_fault,
  input wire logic        i_double_fault_guard_enable,
  input wire logic        i_decode_dispatch_request,
  input wire logic        i_float_option_present,
  // Outputs of the block.
  input wire logic [15:0] o_instruction_holding_register,
  input wire logic [7:0]  o_micro_program_counter_oe_n,
  input wire logic        o_trap_class_bit0,
  input wire logic        o_reserved_trap,
  input wire logic        o_illegal_trap
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_rstn);
  // Short aliases of the watched ports.
  wire       g   = i_bus_fault && i_double_fault_guard_enable;
  wire       svc = i_service_branch_test;
  wire       req = i_decode_dispatch_request;
  wire [15:0] ir = o_instruction_holding_register;
  wire [7:0]  oe = o_micro_program_counter_oe_n;
  // Service level seen high, then low.
  sequence s_svc_fall;
    svc ##1 !svc;
  endsequence
  // Load strobe together with the clock pulse.
  sequence s_load;
    i_processor_clock_pulse && i_load_instruction_strobe;
  endsequence
  a_load_takes_word: assert property (
    s_load ##0 !g ##0 !($past(svc) && !svc) |=> ir == $past(i_source_select_multiplexer))
    else $error("loaded word not held");
  a_svc_sets_branch: assert property (s_svc_fall ##0 !g |=> ir == 16'h8000)
    else $error("service edge pattern wrong");
  a_fault_halts_ir: assert property (g |=> ir == 16'h0000)
    else $error("guarded fault did not clear");
  a_ir_stays_put: assert property (
    !g && !(i_processor_clock_pulse && i_load_instruction_strobe) && !($past(svc) && !svc) |=> $stable(ir))
    else $error("held word changed");
  a_idle_lines_free: assert property (
    !req |=> oe == 8'hff && !o_trap_class_bit0 && !o_reserved_trap && !o_illegal_trap)
    else $error("lines driven without request");
  a_src_mode_gated: assert property (o_trap_class_bit0 |-> oe[2:0] == ~$past(ir[11:9]))
    else $error("source mode not on low bits");
  a_resv_trap_set: assert property (
    req && ir[15:12] == 4'hf && !i_float_option_present |=> o_reserved_trap && oe == 8'hff)
    else $error("reserved opcode not trapped");
  a_float_no_trap: assert property (req && i_float_option_present |=> !o_reserved_trap)
    else $error("trap with float option");
  a_mov_code_out: assert property (
    req && ir[15:9] == 7'h08 && ir[5:3] == 3'h0 |=> oe == 8'h77 && o_trap_class_bit0)
    else $error("move branch code wrong");
endmodule

//--- verification/ird_cs_model.sv
/*
  Control store and micro-PC sequencer model at the wired-OR side.
  Assumes the bench supplies each next microword after a falling edge.
*/
module ird_cs_model (
  // Clock and reset.
  input  wire logic        i_mclk,
  input  wire logic        i_rstn,
  // Next microword and the decoder's line drive.
  input  wire logic [39:0] i_uword_next,
  input  wire logic [7:0]  i_mpc_out,
  input  wire logic [7:0]  i_mpc_oe_n,
  // Registered controls and the resolved next address.
  output logic             o_dispatch,
  output logic             o_guard,
  output logic [8:0]       o_next_addr
);
  logic [39:0] uword_reg; // Forty control signals
  logic [7:0]  line;      // Line level, pulled up when nobody drives.
  // Microword changes only on the clock edge
  always_ff @(posedge i_mclk or negedge i_rstn)
    if (!i_rstn) uword_reg <= 40'h0;
    else uword_reg <= i_uword_next;
  assign o_dispatch = uword_reg[9];
  // Guard is raised only by trap microwords of the stimulus
  assign o_guard = uword_reg[10];
  // Either party pulling a line low makes it a 1
  assign line = (i_mpc_oe_n | i_mpc_out) & ~uword_reg[7:0];
  assign o_next_addr = {uword_reg[8], ~line};
endmodule

//--- verification/ird_top_tb_top.sv
/*
  Self-checking bench for ird_top with a control store model.
  Assumes ird_pkg, the design and the model are compiled first.
*/
module ird_top_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 1'h0, rstn = 1'h0, pul = 1'h0, stb = 1'h0; // Clock, reset, pulse, strobe.
  logic        svc = 1'h0, flt = 1'h0, flo = 1'h0, alu = 1'h0;  // Event and mode inputs.
  logic [15:0] mux = 16'h0;                                     // Word to load.
  logic [39:0] uw  = 40'h0;                                     // Next microword.
  wire  [15:0] ir;                                              // Held word.
  wire  [7:0]  mo, oe;                                          // Line value and enables.
  wire  [2:0]  ao;                                              // Auxiliary ALU op.
  wire         tc, rs, il, aa, req, grd;                        // Flags and model controls.
  wire  [8:0]  nxt;                                             // Next micro-PC address.
  int          err_total = 0, n_checks = 0;                     // Mismatch and compare counts.
  // Dispatch table: word, then {tc0, code}.
  localparam logic [23:0] TBL [11] = '{24'h100031, 24'h120029, 24'he00034, 24'h200037, 24'hb00037,
    24'h600029, 24'h6e082c, 24'h50082c, 24'hc00029, 24'h000000, 24'h700000};
  ird_top i_ird_top (.i_mclk(clk), .i_rstn(rstn), .i_processor_clock_pulse(pul),
    .i_load_instruction_strobe(stb), .i_source_select_multiplexer(mux), .i_service_branch_test(svc),
    .i_bus_fault(flt), .i_double_fault_guard_enable(grd), .i_decode_dispatch_request(req),
    .i_float_option_present(flo), .i_generic_alu_step(alu), .o_instruction_holding_register(ir),
    .o_micro_program_counter_out(mo), .o_micro_program_counter_oe_n(oe), .o_trap_class_bit0(tc),
    .o_reserved_trap(rs), .o_illegal_trap(il), .o_aux_alu_active(aa), .o_aux_alu_op(ao));
  ird_cs_model i_ird_cs_model (.i_mclk(clk), .i_rstn(rstn), .i_uword_next(uw), .i_mpc_out(mo),
    .i_mpc_oe_n(oe), .o_dispatch(req), .o_guard(grd), .o_next_addr(nxt));
  // Clock of 100 ns.
  initial forever #50 clk = ~clk;
  // Compares a word-sized result.
  task chk(input string n, input logic [15:0] e, input logic [15:0] g);
    n_checks++;
    if (g !== e)
    begin
      err_total++;
      $display("[FAIL] %s exp %h got %h", n, e, g);
    end
  endtask
  // Compares a one-bit flag.
  task chk_f(input string n, input logic e, input logic g);
    chk(n, {15'h0, e}, {15'h0, g});
  endtask
  // Waits n falling edges.
  task stp(input int n);
    repeat (n) @(negedge clk);
  endtask
  // Loads one word with strobe and pulse for one edge.
  task ld(input logic [15:0] w);
    mux = w; stb = 1'h1; pul = 1'h1;
    stp(1);
    stb = 1'h0; pul = 1'h0;
  endtask
  // Strobe alone is ignored; strobe with pulse loads.
  task t_load;
    ld(16'h1234);
    chk("ir", 16'h1234, ir);
    mux = 16'hffff; stb = 1'h1;
    stp(1);
    stb = 1'h0;
    chk("ir", 16'h1234, ir);
  endtask
  // Service falling edge wins over a load at the same edge.
  task t_service;
    svc = 1'h1;
    stp(1);
    svc = 1'h0; mux = 16'habcd; stb = 1'h1; pul = 1'h1;
    stp(1);
    stb = 1'h0; pul = 1'h0;
    chk("ir", 16'h8000, ir);
  endtask
  // Unguarded fault keeps the word; guarded fault beats a load.
  task t_fault;
    flt = 1'h1;
    stp(1);
    flt = 1'h0; uw = 40'h400;
    chk("ir", 16'h8000, ir);
    stp(1);
    flt = 1'h1; mux = 16'h5555; stb = 1'h1; pul = 1'h1;
    stp(1);
    flt = 1'h0; stb = 1'h0; pul = 1'h0; uw = 40'h0;
    chk("ir", 16'h0000, ir);
  endtask
  // Every two-operand class but the reserved one through the table.
  task t_dispatch;
    logic [15:0] e;
    uw = 40'h200;
    foreach (TBL[k])
    begin
      ld(TBL[k][23:8]);
      stp(1);
      e = TBL[k][5] ? {8'h0, TBL[k][4:0], TBL[k][19:17]} : 16'h0;
      chk("next_addr", e, {7'h0, nxt});
      chk_f("trap_class0", TBL[k][5], tc);
    end
  endtask
  // Reserved, float and illegal pairings.
  task t_traps;
    ld(16'hf000);
    stp(1);
    chk_f("reserved", 1'h1, rs);
    chk("next_addr", 16'h0, {7'h0, nxt});
    flo = 1'h1;
    stp(1);
    chk_f("reserved", 1'h0, rs);
    ld(16'h0040);
    stp(1);
    chk_f("illegal", 1'h1, il);
    ld(16'h0048);
    stp(1);
    chk_f("illegal", 1'h0, il);
    ld(16'h0800);
    stp(1);
    chk_f("illegal", 1'h1, il);
  endtask
  // Request drops: own address passes untouched.
  task t_release;
    ld(16'h1000);
    uw = 40'h0ab;
    stp(2);
    chk("next_addr", 16'h00ab, {7'h0, nxt});
    chk("oe_n", 16'h00ff, {8'h0, oe});
  endtask
  // Auxiliary ALU control follows the generic step.
  task t_aux;
    ld(16'h6000);
    alu = 1'h1;
    stp(1);
    chk_f("aux_active", 1'h1, aa);
    chk("aux_op", 16'h0006, {13'h0, ao});
    alu = 1'h0;
    stp(1);
    chk_f("aux_active", 1'h0, aa);
  endtask
  // Prints the counts and the verdict, then stops.
  task complete_run;
    $display("errors %0d checks %0d", err_total, n_checks);
    if (err_total == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // Main sequence after a two-cycle reset.
  initial
  begin
    stp(2);
    rstn = 1'h1;
    chk("ir", 16'h8000, ir);
    t_load();
    t_service();
    t_fault();
    t_dispatch();
    t_traps();
    t_release();
    t_aux();
    complete_run();
  end
  // Cuts a hang short.
  initial
  begin
    #50us;
    err_total++;
    complete_run();
  end
endmodule
bind ird_top ird_top_properties i_ird_top_properties (.i_mclk, .i_rstn, .i_processor_clock_pulse,
  .i_load_instruction_strobe, .i_source_select_multiplexer, .i_service_branch_test, .i_bus_fault,
  .i_double_fault_guard_enable, .i_decode_dispatch_request, .i_float_option_present,
  .o_instruction_holding_register, .o_micro_program_counter_oe_n, .o_trap_class_bit0,
  .o_reserved_trap, .o_illegal_trap);
